// ===== vpw_consts.vh
`ifndef VPW_CONSTS_VH
`define VPW_CONSTS_VH

// Register byte offsets
`define VPW_OFS_CTL1        8'h00
`define VPW_OFS_CTL2        8'h04
`define VPW_OFS_DATA        8'h08
`define VPW_OFS_STATE       8'h0C

// Field positions
`define VPW_CTL1_IRQ_EN     0
`define VPW_CTL2_LOOP       0
`define VPW_CTL2_FAST_EN    1
`define VPW_SV_RX_FULL      0
`define VPW_SV_RX_RESP      1
`define VPW_SV_TX_EMPTY     2
`define VPW_SV_CRC_ERR      3
`define VPW_SV_INV_SYM      4
`define VPW_SV_ARB_LOST     5
`define VPW_SV_TX_ERR       6

// Reset values
`define VPW_FLAGS_RST       7'h04

// Link clock period and its count of pclk cycles (pclk period 25 ns)
`define VPW_PCLK_NS         25
`define VPW_LINK_NS         1000
`define VPW_LINK_DIV        (`VPW_LINK_NS / `VPW_PCLK_NS)

// Receive windows in link clock periods
`define VPW_BIT_MIN         11'h0022
`define VPW_BIT_MID         11'h0060
`define VPW_BIT_MAX         11'h00A3
`define VPW_SOF_MAX         11'h00EF
`define VPW_EOF_MIN         11'h00EF
`define VPW_IDLE_MIN        11'h012C
`define VPW_FSOF_MIN        9'h028
`define VPW_FSOF_MAX        9'h03C
`define VPW_JOIN_MAX        9'h068
`define VPW_CNT_SAT         9'h1FF

// Transmit symbol lengths in link clock periods
`define VPW_T_SHORT         9'h040
`define VPW_T_LONG          9'h080
`define VPW_T_SOF           9'h0C8

// Frame check
`define VPW_CRC_POLY        8'h1D
`define VPW_CRC_INIT        8'hFF
`define VPW_CRC_RESIDUE     8'hC4

`endif

// ===== vpw_protocol_handler.v
`include "vpw_consts.vh"
`default_nettype none

module vpw_protocol_handler #(
    parameter LINK_DIV = `VPW_LINK_DIV
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        bus_rx_pin,
    output wire        bus_tx_pin,
    output wire        irq
);

    localparam [7:0] DIV_M1 = LINK_DIV[7:0] - 8'h01;

    localparam [1:0] R_WAIT = 2'd0;
    localparam [1:0] R_DATA = 2'd1;
    localparam [1:0] R_EOD  = 2'd2;
    localparam [1:0] R_IGN  = 2'd3;

    localparam [2:0] T_IDLE = 3'd0;
    localparam [2:0] T_SOF  = 3'd1;
    localparam [2:0] T_BIT  = 3'd2;
    localparam [2:0] T_EXT  = 3'd3;
    localparam [2:0] T_EOD  = 3'd4;

    reg  [31:0] prdata_r;
    reg         pready_r;
    reg         pslverr_r;
    reg         tx_pin_r;
    reg         irq_r;
    reg         irq_en_r;
    reg         loop_r;
    reg         fast_en_r;
    reg  [6:0]  flags_r;
    reg         s1_r;
    reg         s2_r;
    reg         lvl_r;
    reg  [7:0]  pre_r;
    reg  [8:0]  cnt_r;
    reg         idle_r;
    reg         fast_r;
    reg  [1:0]  rx_st_r;
    reg  [6:0]  rx_sh_r;
    reg  [2:0]  rx_cnt_r;
    reg  [7:0]  rx_shadow_r;
    reg  [7:0]  rx_crc_r;
    reg         resp_r;
    reg  [2:0]  tx_st_r;
    reg  [7:0]  tx_sh_r;
    reg  [2:0]  tx_cnt_r;
    reg  [7:0]  tx_shadow_r;
    reg         sh_full_r;
    reg  [7:0]  tx_crc_r;
    reg         crc_sent_r;
    reg         ext_r;
    reg  [31:0] rd_nxt;
    reg  [8:0]  tgt_nxt;
    reg         drive_nxt;

    function [7:0] crc8;
        input [7:0] c;
        input [7:0] d;
        integer     i;
        reg   [7:0] x;
        begin
            x = c;
            for (i = 7; i >= 0; i = i - 1) begin
                if (x[7] ^ d[i])
                    x = {x[6:0], 1'b0} ^ `VPW_CRC_POLY;
                else
                    x = {x[6:0], 1'b0};
            end
            crc8 = x;
        end
    endfunction

    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign bus_tx_pin = tx_pin_r;
    assign irq        = irq_r;

    wire        rxd      = loop_r ? tx_pin_r : s2_r;
    wire        edge_w   = rxd != lvl_r;
    wire        tick     = pre_r == DIV_M1;
    wire [10:0] dur      = fast_r ? {cnt_r, 2'b00} : {2'b00, cnt_r};
    wire        bit_ok   = (dur >= `VPW_BIT_MIN) && (dur < `VPW_BIT_MAX);
    // Short active or long passive is a 1, the reverse a 0
    wire        rbit     = lvl_r ? (dur < `VPW_BIT_MID)
                                 : (dur >= `VPW_BIT_MID);
    wire        sof_ok   = lvl_r && (dur >= `VPW_BIT_MAX)
                           && (dur < `VPW_SOF_MAX);
    wire        fsof_ok  = lvl_r && (cnt_r >= `VPW_FSOF_MIN)
                           && (cnt_r < `VPW_FSOF_MAX);
    wire [7:0]  rx_byte  = {rx_sh_r, rbit};
    wire        sb       = (tx_st_r == T_EXT) ? 1'b1 : tx_sh_r[7];
    wire        apb_done = psel && penable && pready_r;
    wire        hit      = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'b00);
    wire        bit_edge = edge_w && (rx_st_r == R_DATA);

    always @* begin
        rd_nxt = 32'h0000_0000;
        case (paddr)
            `VPW_OFS_CTL1:  rd_nxt[`VPW_CTL1_IRQ_EN] = irq_en_r;
            `VPW_OFS_CTL2:  rd_nxt[1:0] = {fast_en_r, loop_r};
            `VPW_OFS_DATA:  rd_nxt[7:0] = rx_shadow_r;
            `VPW_OFS_STATE: rd_nxt[6:0] = flags_r;
            default:        rd_nxt = 32'h0000_0000;
        endcase
    end

    // Symbol length: a 0 is long when active, a 1 long when passive
    always @* begin
        if (tx_st_r == T_SOF)
            tgt_nxt = `VPW_T_SOF;
        else if (lvl_r ^ sb)
            tgt_nxt = `VPW_T_LONG;
        else
            tgt_nxt = `VPW_T_SHORT;
        if ((tx_st_r == T_IDLE) || (tx_st_r == T_EOD))
            drive_nxt = 1'b0;
        else if (lvl_r)
            drive_nxt = cnt_r < tgt_nxt;
        else
            drive_nxt = cnt_r >= tgt_nxt;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r    <= 32'h0000_0000;
            pready_r    <= 1'b0;
            pslverr_r   <= 1'b0;
            tx_pin_r    <= 1'b0;
            irq_r       <= 1'b0;
            irq_en_r    <= 1'b0;
            loop_r      <= 1'b0;
            fast_en_r   <= 1'b0;
            flags_r     <= `VPW_FLAGS_RST;
            s1_r        <= 1'b0;
            s2_r        <= 1'b0;
            lvl_r       <= 1'b0;
            pre_r       <= 8'h00;
            cnt_r       <= 9'h000;
            idle_r      <= 1'b0;
            fast_r      <= 1'b0;
            rx_st_r     <= R_IGN;
            rx_sh_r     <= 7'h00;
            rx_cnt_r    <= 3'd0;
            rx_shadow_r <= 8'h00;
            rx_crc_r    <= `VPW_CRC_INIT;
            resp_r      <= 1'b0;
            tx_st_r     <= T_IDLE;
            tx_sh_r     <= 8'h00;
            tx_cnt_r    <= 3'd0;
            tx_shadow_r <= 8'h00;
            sh_full_r   <= 1'b0;
            tx_crc_r    <= `VPW_CRC_INIT;
            crc_sent_r  <= 1'b0;
            ext_r       <= 1'b0;
        end else begin
            s1_r  <= bus_rx_pin;
            s2_r  <= s1_r;
            lvl_r <= rxd;
            if (edge_w) begin
                pre_r <= 8'h00;
                cnt_r <= 9'h000;
                idle_r <= 1'b0;
            end else begin
                pre_r <= tick ? 8'h00 : pre_r + 8'h01;
                if (tick && (cnt_r != `VPW_CNT_SAT))
                    cnt_r <= cnt_r + 9'h001;
            end

            // Bus slave: one wait state, effects at the completing edge
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            if (psel && penable && !pready_r) begin
                pready_r  <= 1'b1;
                pslverr_r <= !hit;
                prdata_r  <= rd_nxt;
            end
            if (apb_done && pwrite) begin
                case (paddr)
                    `VPW_OFS_CTL1: irq_en_r <= pwdata[`VPW_CTL1_IRQ_EN];
                    `VPW_OFS_CTL2: begin
                        loop_r    <= pwdata[`VPW_CTL2_LOOP];
                        fast_en_r <= pwdata[`VPW_CTL2_FAST_EN];
                    end
                    `VPW_OFS_DATA: begin
                        tx_shadow_r <= pwdata[7:0];
                        sh_full_r   <= 1'b1;
                        flags_r[`VPW_SV_TX_EMPTY] <= 1'b0;
                    end
                    default: ;
                endcase
            end
            // Clears sit before the sets below so that a set wins
            if (apb_done && !pwrite && (paddr == `VPW_OFS_DATA)) begin
                flags_r[`VPW_SV_RX_FULL] <= 1'b0;
                flags_r[`VPW_SV_RX_RESP] <= 1'b0;
            end
            if (apb_done && !pwrite && (paddr == `VPW_OFS_STATE))
                flags_r[6:3] <= 4'h0;

            // Receiver
            if (!lvl_r && !edge_w && (dur >= `VPW_IDLE_MIN)) begin
                idle_r <= 1'b1;
                fast_r <= 1'b0;
                if (rx_st_r == R_IGN)
                    rx_st_r <= R_WAIT;
            end
            case (rx_st_r)
                R_WAIT: begin
                    if (edge_w && lvl_r) begin
                        rx_cnt_r <= 3'd0;
                        rx_crc_r <= `VPW_CRC_INIT;
                        resp_r   <= 1'b0;
                        if (sof_ok) begin
                            rx_st_r <= R_DATA;
                        end else if (fsof_ok && fast_en_r) begin
                            fast_r  <= 1'b1;
                            rx_st_r <= R_DATA;
                        end else begin
                            rx_st_r <= R_IGN;
                            if (dur >= `VPW_SOF_MAX)
                                flags_r[`VPW_SV_INV_SYM] <= 1'b1;
                        end
                    end
                end
                R_DATA: begin
                    if (edge_w) begin
                        if (bit_ok) begin
                            rx_sh_r  <= rx_byte[6:0];
                            rx_cnt_r <= rx_cnt_r + 3'd1;
                            // No byte limit: frames run until end-of-data
                            if (rx_cnt_r == 3'd7) begin
                                rx_shadow_r <= rx_byte;
                                rx_crc_r    <= crc8(rx_crc_r, rx_byte);
                                if (resp_r)
                                    flags_r[`VPW_SV_RX_RESP] <= 1'b1;
                                else
                                    flags_r[`VPW_SV_RX_FULL] <= 1'b1;
                            end
                        end else begin
                            flags_r[`VPW_SV_INV_SYM] <= 1'b1;
                            rx_st_r <= R_IGN;
                        end
                    end else if (!lvl_r && (dur >= `VPW_BIT_MAX)) begin
                        rx_st_r <= R_EOD;
                        if (rx_cnt_r != 3'd0)
                            flags_r[`VPW_SV_INV_SYM] <= 1'b1;
                        else if (rx_crc_r != `VPW_CRC_RESIDUE)
                            flags_r[`VPW_SV_CRC_ERR] <= 1'b1;
                    end
                end
                R_EOD: begin
                    if (edge_w) begin
                        rx_st_r  <= R_DATA;
                        rx_cnt_r <= 3'd0;
                        rx_crc_r <= `VPW_CRC_INIT;
                        resp_r   <= 1'b1;
                    end else if (dur >= `VPW_EOF_MIN) begin
                        rx_st_r <= R_WAIT;
                        fast_r  <= 1'b0;
                    end
                end
                default: ;
            endcase

            // Transmitter
            case (tx_st_r)
                T_IDLE: begin
                    if (sh_full_r && !fast_r) begin
                        if (idle_r)
                            tx_st_r <= T_SOF;
                        else if ((rx_st_r == R_WAIT) && lvl_r
                                 && (cnt_r <= `VPW_JOIN_MAX))
                            tx_st_r <= T_SOF;
                    end
                end
                T_SOF: begin
                    if (edge_w && lvl_r) begin
                        if (sof_ok) begin
                            tx_st_r     <= T_BIT;
                            tx_sh_r     <= tx_shadow_r;
                            tx_crc_r    <= crc8(`VPW_CRC_INIT, tx_shadow_r);
                            tx_cnt_r    <= 3'd0;
                            crc_sent_r  <= 1'b0;
                            sh_full_r   <= 1'b0;
                            flags_r[`VPW_SV_TX_EMPTY] <= 1'b1;
                        end else begin
                            tx_st_r <= T_IDLE;
                            flags_r[`VPW_SV_TX_ERR] <= 1'b1;
                        end
                    end
                end
                T_BIT: begin
                    if (bit_edge && !bit_ok) begin
                        tx_st_r <= T_IDLE;
                        flags_r[`VPW_SV_TX_ERR] <= 1'b1;
                        flags_r[`VPW_SV_INV_SYM] <= 1'b1;
                    end else if (bit_edge && (rbit != sb)) begin
                        if (sb) begin
                            flags_r[`VPW_SV_ARB_LOST] <= 1'b1;
                            if (tx_cnt_r == 3'd7) begin
                                tx_st_r <= T_EXT;
                                ext_r   <= 1'b1;
                            end else begin
                                tx_st_r <= T_IDLE;
                            end
                        end else begin
                            tx_st_r <= T_IDLE;
                            flags_r[`VPW_SV_TX_ERR] <= 1'b1;
                        end
                    end else if (bit_edge) begin
                        tx_sh_r  <= {tx_sh_r[6:0], 1'b0};
                        tx_cnt_r <= tx_cnt_r + 3'd1;
                        if (tx_cnt_r == 3'd7) begin
                            if (sh_full_r) begin
                                tx_sh_r   <= tx_shadow_r;
                                tx_crc_r  <= crc8(tx_crc_r, tx_shadow_r);
                                sh_full_r <= 1'b0;
                                flags_r[`VPW_SV_TX_EMPTY] <= 1'b1;
                            end else if (!crc_sent_r) begin
                                tx_sh_r    <= ~tx_crc_r;
                                crc_sent_r <= 1'b1;
                            end else begin
                                tx_st_r <= T_EOD;
                            end
                        end
                    end
                end
                T_EXT: begin
                    if (bit_edge) begin
                        if (!bit_ok || !rbit || !ext_r)
                            tx_st_r <= T_IDLE;
                        ext_r <= 1'b0;
                    end
                end
                T_EOD: begin
                    if (edge_w) begin
                        tx_st_r <= T_IDLE;
                        flags_r[`VPW_SV_INV_SYM] <= 1'b1;
                        flags_r[`VPW_SV_TX_ERR]  <= 1'b1;
                    end else if (rx_st_r != R_DATA) begin
                        tx_st_r <= T_IDLE;
                    end
                end
                default: tx_st_r <= T_IDLE;
            endcase
            if ((rx_st_r == R_DATA) && (tx_st_r != T_IDLE) && !edge_w
                && !lvl_r && (dur >= `VPW_BIT_MAX) && (tx_st_r != T_EOD))
                tx_st_r <= T_IDLE;

            tx_pin_r <= drive_nxt;
            irq_r    <= irq_en_r && (|flags_r);
        end
    end

endmodule // vpw_protocol_handler

`default_nettype wire

// ===== vpw_checker.sv
`include "vpw_consts.vh"
`default_nettype none

module vpw_checker #(
    parameter int LINK_DIV = 40
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        bus_rx_pin,
    input wire logic        bus_tx_pin,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HI_MIN = 64 * LINK_DIV - 1;
    localparam int HI_MAX = 200 * LINK_DIV + 8;
    localparam int EOF_MIN = 239 * LINK_DIV;
    localparam int JOIN_MAX = 104 * LINK_DIV + 8;
    localparam logic [15:0] SAT = 16'(300 * LINK_DIV);
    logic [15:0] tx_hi_r;
    logic [15:0] tx_lo_r;
    logic [15:0] rx_hi_r;
    logic [15:0] rx_lo_r;
    logic        ie_r;

    // Run lengths of both lines; the low side saturates at idle length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_hi_r <= 16'h0000;
            tx_lo_r <= SAT;
            rx_hi_r <= 16'h0000;
            rx_lo_r <= SAT;
            ie_r    <= 1'b0;
        end else begin
            tx_hi_r <= bus_tx_pin ? tx_hi_r + 16'h0001 : 16'h0000;
            tx_lo_r <= bus_tx_pin ? 16'h0000
                     : (tx_lo_r == SAT) ? SAT : tx_lo_r + 16'h0001;
            rx_hi_r <= bus_rx_pin ? rx_hi_r + 16'h0001 : 16'h0000;
            rx_lo_r <= bus_rx_pin ? 16'h0000
                     : (rx_lo_r == SAT) ? SAT : rx_lo_r + 16'h0001;
            if (psel && penable && pready && pwrite
                    && paddr == `VPW_OFS_CTL1) begin
                ie_r <= pwdata[`VPW_CTL1_IRQ_EN];
            end
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_apb_wait;
        psel && penable && !pready |=> pready;
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    property p_unmapped;
        psel && penable && !pready && paddr > `VPW_OFS_STATE |=> pslverr;
    endproperty
    property p_tx_high;
        $fell(bus_tx_pin) |-> tx_hi_r >= HI_MIN && tx_hi_r <= HI_MAX;
    endproperty
    property p_tx_low;
        $rose(bus_tx_pin) && tx_lo_r != SAT |-> tx_lo_r >= HI_MIN;
    endproperty
    property p_tx_start;
        $rose(bus_tx_pin) && tx_lo_r == SAT |->
            rx_lo_r >= EOF_MIN || (rx_hi_r != 0 && rx_hi_r <= JOIN_MAX);
    endproperty
    property p_irq_mask;
        !ie_r && !$past(ie_r) |-> !irq;
    endproperty

    a_apb_wait: assert property (p_apb_wait)
        else $error("no answer one cycle after access");
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (p_err_ready)
        else $error("pslverr without pready");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
    a_tx_high: assert property (p_tx_high)
        else $error("active pulse length out of range");
    a_tx_low: assert property (p_tx_low)
        else $error("passive period inside frame too short");
    a_tx_start: assert property (p_tx_start)
        else $error("frame started on a busy bus");
    a_irq_mask: assert property (p_irq_mask)
        else $error("irq raised while disabled");

    c_join: cover property ($rose(bus_tx_pin) && rx_hi_r != 0);
    c_refused: cover property (pslverr);
    c_irq: cover property ($rose(irq));
    c_sof: cover property ($fell(bus_tx_pin) && tx_hi_r > HI_MIN * 3);
endmodule // vpw_checker

bind vpw_protocol_handler vpw_checker #(.LINK_DIV(LINK_DIV)) vpw_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .bus_rx_pin(bus_rx_pin), .bus_tx_pin(bus_tx_pin),
    .irq(irq));

`default_nettype wire

// ===== vpw_node_model.sv
`default_nettype none

module vpw_node_model #(
    parameter int LINK_DIV = 40
) (
    input  wire logic pclk,
    input  wire logic dut_tx,
    output wire logic bus_rx_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic node_act_r = 1'b0;

    // Wired-OR bus with pull-down: any active driver dominates
    assign bus_rx_pin = node_act_r | dut_tx;

    task automatic sym(input logic act, input int len, input int div);
        node_act_r <= act;
        repeat (len * LINK_DIV / div) @(posedge pclk);
    endtask

    function automatic logic [7:0] crc_of(input logic [7:0] d);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 7; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1D : 8'h00);
        end
        return ~c;
    endfunction

    // One data byte plus check byte; div 4 gives the fast rate
    task automatic send_frame(input logic [7:0] d, input logic bad,
                              input int div);
        logic [15:0] w;
        logic        lvl;
        w = {d, crc_of(d) ^ {7'h00, bad}};
        lvl = 1'b0;
        sym(1'b1, 200, div);
        for (int i = 15; i >= 0; i--) begin
            sym(lvl, (w[i] ^ lvl) ? 128 : 64, div);
            lvl = ~lvl;
        end
        sym(1'b0, 300, 1);
    endtask

    task automatic send_noise();
        sym(1'b1, 200, 1);
        sym(1'b0, 10, 1);
        sym(1'b1, 64, 1);
        sym(1'b0, 300, 1);
    endtask
endmodule // vpw_node_model

`default_nettype wire

// ===== test_vpw_protocol_handler.sv
`include "vpw_consts.vh"
`default_nettype none

module test_vpw_protocol_handler;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LD = 4;
    typedef struct packed {
        logic [31:0] exp;
        logic [31:0] mask;
        logic        err;
    } vpw_note_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        bus_rx_pin;
    logic        bus_tx_pin;
    logic        irq;
    logic [7:0]  rnd;
    logic        seen;
    vpw_note_t   cur;
    vpw_note_t   notes_q[$];
    int          fail_count = 0;
    int          samples_checked = 0;
    int          cyc = 0;

    always #12.5 pclk = ~pclk;

    vpw_protocol_handler #(.LINK_DIV(LD)) vpw_protocol_handler_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus_rx_pin(bus_rx_pin),
        .bus_tx_pin(bus_tx_pin), .irq(irq));
    vpw_node_model #(.LINK_DIV(LD)) vpw_node_model_inst (
        .pclk(pclk), .dut_tx(bus_tx_pin), .bus_rx_pin(bus_rx_pin));

    task automatic test_done();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp,
                            input logic [31:0] mask);
        samples_checked++;
        if ((got & mask) !== (exp & mask)) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && t < 20) begin
            @(posedge pclk);
            t++;
        end
        if (t == 20) begin
            fail_count++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic [31:0] mask);
        notes_q.push_back({exp, mask, a > `VPW_OFS_STATE});
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (n < 320 * LD) begin
            @(posedge pclk);
            n = bus_rx_pin ? 0 : n + 1;
        end
    endtask

    // Result watcher and run limit
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (notes_q.size() == 0) begin
                cmp_bit(1'b1, 1'b0);
            end else begin
                cur = notes_q.pop_front();
                cmp_word(prdata, cur.exp, cur.mask);
                cmp_bit(pslverr, cur.err);
            end
        end
        cyc++;
        if (cyc == 95000) begin
            fail_count++;
            test_done();
        end
    end

    initial begin
        void'($urandom(81));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`VPW_OFS_CTL1, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(`VPW_OFS_CTL2, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(`VPW_OFS_STATE, 32'h0000_0004, 32'hFFFF_FFFF);
        rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF);
        wr(`VPW_OFS_CTL1, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        cmp_bit(irq, 1'b1);
        wr(`VPW_OFS_CTL1, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        cmp_bit(irq, 1'b0);
        wait_idle();
        wr(`VPW_OFS_CTL2, 32'h0000_0001);
        rnd = 8'($urandom());
        wr(`VPW_OFS_DATA, {24'h00_0000, rnd});
        rd(`VPW_OFS_STATE, 32'h0000_0000, 32'h0000_0004);
        wait_idle();
        rd(`VPW_OFS_STATE, 32'h0000_0005, 32'h0000_001D);
        // The check byte is the last one shifted in, so the shadow holds it
        rd(`VPW_OFS_DATA, {24'h00_0000, vpw_node_model_inst.crc_of(rnd)},
           32'h0000_00FF);
        wr(`VPW_OFS_CTL2, 32'h0000_0000);
        rnd = 8'($urandom());
        vpw_node_model_inst.send_frame(rnd, 1'b0, 1);
        rd(`VPW_OFS_STATE, 32'h0000_0001, 32'h0000_0019);
        rd(`VPW_OFS_DATA, {24'h00_0000, vpw_node_model_inst.crc_of(rnd)},
           32'h0000_00FF);
        vpw_node_model_inst.send_frame(8'hA5, 1'b1, 1);
        rd(`VPW_OFS_STATE, 32'h0000_0008, 32'h0000_0008);
        rd(`VPW_OFS_DATA,
           {24'h00_0000, vpw_node_model_inst.crc_of(8'hA5) ^ 8'h01},
           32'h0000_00FF);
        vpw_node_model_inst.send_noise();
        rd(`VPW_OFS_STATE, 32'h0000_0010, 32'h0000_0010);
        vpw_node_model_inst.send_frame(8'h3C, 1'b0, 4);
        rd(`VPW_OFS_STATE, 32'h0000_0000, 32'h0000_0009);
        wr(`VPW_OFS_CTL2, 32'h0000_0002);
        vpw_node_model_inst.send_frame(8'hC3, 1'b0, 4);
        rd(`VPW_OFS_STATE, 32'h0000_0001, 32'h0000_0009);
        rd(`VPW_OFS_DATA, {24'h00_0000, vpw_node_model_inst.crc_of(8'hC3)},
           32'h0000_00FF);
        wr(`VPW_OFS_CTL2, 32'h0000_0000);
        fork
            vpw_node_model_inst.send_frame(8'h00, 1'b0, 1);
            begin
                repeat (4 * LD) @(posedge pclk);
                wr(`VPW_OFS_DATA, 32'h0000_0001);
                seen = 1'b0;
                repeat (100 * LD) begin
                    @(posedge pclk);
                    seen |= bus_tx_pin;
                end
            end
        join
        cmp_bit(seen, 1'b1);
        wait_idle();
        rd(`VPW_OFS_STATE, 32'h0000_0020, 32'h0000_0020);
        rd(`VPW_OFS_STATE, 32'h0000_0004, 32'h0000_0004);
        fork
            vpw_node_model_inst.send_frame(8'h55, 1'b0, 1);
            begin
                repeat (400 * LD) @(posedge pclk);
                wr(`VPW_OFS_DATA, 32'h0000_0033);
                seen = 1'b0;
                repeat (600 * LD) begin
                    @(posedge pclk);
                    seen |= bus_tx_pin;
                end
            end
        join
        cmp_bit(seen, 1'b0);
        seen = 1'b0;
        repeat (300 * LD) begin
            @(posedge pclk);
            seen |= bus_tx_pin;
        end
        cmp_bit(seen, 1'b1);
        wait_idle();
        rd(`VPW_OFS_STATE, 32'h0000_0004, 32'h0000_0004);
        test_done();
    end
endmodule // test_vpw_protocol_handler

`default_nettype wire
